// File: pkg/lvd_pkg.sv
// package: register map, field positions and timing constants for the low-voltage detector control
package lvd_pkg;
    // register byte addresses on the wishbone bus
    localparam logic [3:0] LVD_ADDR_CTRL = 4'h0;
    localparam logic [3:0] LVD_ADDR_IRQF = 4'h4;
    localparam logic [3:0] LVD_ADDR_MASK = 4'h8;
    localparam logic [3:0] LVD_ADDR_STAT = 4'hC;
    // control register fields
    localparam int LVD_BIT_ON = 7;
    localparam int LVD_BIT_SRC = 2;
    localparam int LVD_BIT_MODE = 1;
    localparam int LVD_BIT_LEVEL = 0;
    // irq flag register field
    localparam int LVD_BIT_REQ = 0;
    // reset values
    localparam logic [7:0] LVD_CTRL_RESET = 8'h00;
    localparam logic LVD_MASK_RESET = 1'b1;
    // status register: bit 0 request pulse seen, bit 1 internal reset seen
    localparam int LVD_BIT_STAT_RST = 1;
    // stabilisation time, informative for software
    localparam int LVD_STAB_TIME_NS = 10000;
    localparam int LVD_CLK_PERIOD_NS = 40;
    localparam int LVD_STAB_CYCLES = (LVD_STAB_TIME_NS + LVD_CLK_PERIOD_NS - 1) / LVD_CLK_PERIOD_NS;
endpackage : lvd_pkg

// File: src/lvd_sync.sv
// two-stage synchroniser for one asynchronous level
`timescale 1ns/1ps
module lvd_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o
);
    import lvd_pkg::*;
    logic meta_reg;
    logic sync_reg;
    // the first stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
        end
    end
    assign q_o = sync_reg;
endmodule : lvd_sync

// File: src/lvd_sticky.sv
// sticky flag: set by a hardware event or a software write, cleared by a software request; set wins
`timescale 1ns/1ps
module lvd_sticky #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic set_i,
    input wire logic clr_i,
    output logic q_o
);
    import lvd_pkg::*;
    logic flag_reg;
    logic flag_next;
    assign flag_next = set_i ? 1'b1 : (clr_i ? 1'b0 : flag_reg);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_reg <= RESET_VAL;
        end else begin
            flag_reg <= flag_next;
        end
    end
    assign q_o = flag_reg;
endmodule : lvd_sticky

// File: src/lvd_ctrl.sv
// low-voltage detector control: registers, crossing detection, interrupt and internal reset
`timescale 1ns/1ps
module lvd_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    // classic wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // analog comparator outputs, high when the input is below its threshold
    input wire logic supply_below_i,
    input wire logic external_below_i,
    output logic low_voltage_irq_o,
    output logic internal_reset_o,
    output logic irq_o
);
    import lvd_pkg::*;

    // ==========================================================
    // bus decode
    logic ack_reg;
    wire bus_req = cyc_i && stb_i && !ack_reg;
    wire wr_lane0 = bus_req && we_i && sel_i[0];
    wire wr_ctrl = wr_lane0 && (adr_i == LVD_ADDR_CTRL);
    wire wr_irqf = wr_lane0 && (adr_i == LVD_ADDR_IRQF);
    wire wr_mask = wr_lane0 && (adr_i == LVD_ADDR_MASK);
    wire wr_stat = wr_lane0 && (adr_i == LVD_ADDR_STAT);

    // ==========================================================
    // control register
    logic detector_on_reg;
    logic sense_source_select_reg;
    logic reset_or_irq_select_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            detector_on_reg <= LVD_CTRL_RESET[LVD_BIT_ON];
            sense_source_select_reg <= LVD_CTRL_RESET[LVD_BIT_SRC];
            reset_or_irq_select_reg <= LVD_CTRL_RESET[LVD_BIT_MODE];
        end else if (wr_ctrl) begin
            detector_on_reg <= dat_i[LVD_BIT_ON];
            sense_source_select_reg <= dat_i[LVD_BIT_SRC];
            reset_or_irq_select_reg <= dat_i[LVD_BIT_MODE];
        end
    end

    // ==========================================================
    // comparator sampling
    logic supply_below_s;
    logic external_below_s;
    lvd_sync u_sync_supply (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(supply_below_i),
        .q_o(supply_below_s)
    );
    lvd_sync u_sync_ext (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(external_below_i),
        .q_o(external_below_s)
    );
    wire sensed_below = sense_source_select_reg ? external_below_s : supply_below_s;

    // level flag follows the selected input only while running
    logic level_below_flag_reg;
    logic on_d_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_below_flag_reg <= 1'b0;
            on_d_reg <= 1'b0;
        end else begin
            level_below_flag_reg <= detector_on_reg ? sensed_below : 1'b0;
            on_d_reg <= detector_on_reg;
        end
    end

    // ==========================================================
    // crossing detection; the first running cycle only loads the level
    wire irq_mode = !reset_or_irq_select_reg;
    wire crossing = detector_on_reg && on_d_reg && (sensed_below != level_below_flag_reg);
    wire stop_below = on_d_reg && !detector_on_reg && level_below_flag_reg;
    wire request_pulse = (crossing || stop_below) && irq_mode;
    logic irq_pulse_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_pulse_reg <= 1'b0;
        end else begin
            irq_pulse_reg <= request_pulse;
        end
    end
    assign low_voltage_irq_o = irq_pulse_reg;

    // reset mode: held while running and below
    logic int_reset_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_reset_reg <= 1'b0;
        end else begin
            int_reset_reg <= detector_on_reg && reset_or_irq_select_reg && sensed_below;
        end
    end
    assign internal_reset_o = int_reset_reg;

    // ==========================================================
    // request flag, mask flag and status
    logic detector_irq_request_flag;
    logic detector_irq_mask;
    logic stat_req;
    logic stat_rst;
    lvd_sticky #(.RESET_VAL(1'b0)) u_req (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(request_pulse),
        .clr_i(wr_irqf && !dat_i[LVD_BIT_REQ]),
        .q_o(detector_irq_request_flag)
    );
    lvd_sticky #(.RESET_VAL(LVD_MASK_RESET)) u_mask (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(wr_mask && dat_i[LVD_BIT_REQ]),
        .clr_i(wr_mask && !dat_i[LVD_BIT_REQ]),
        .q_o(detector_irq_mask)
    );
    lvd_sticky #(.RESET_VAL(1'b0)) u_stat_req (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(request_pulse),
        .clr_i(wr_stat && dat_i[LVD_BIT_REQ]),
        .q_o(stat_req)
    );
    lvd_sticky #(.RESET_VAL(1'b0)) u_stat_rst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(int_reset_reg),
        .clr_i(wr_stat && dat_i[LVD_BIT_STAT_RST]),
        .q_o(stat_rst)
    );
    // interrupt output: pending request not masked
    assign irq_o = detector_irq_request_flag && !detector_irq_mask;

    // ==========================================================
    // read mux and acknowledge
    wire [31:0] rd_ctrl = {24'h00_0000, detector_on_reg, 4'h0, sense_source_select_reg,
                           reset_or_irq_select_reg, level_below_flag_reg};
    wire [31:0] rd_irqf = {31'h0000_0000, detector_irq_request_flag};
    wire [31:0] rd_mask = {31'h0000_0000, detector_irq_mask};
    wire [31:0] rd_stat = {30'h0000_0000, stat_rst, stat_req};
    wire [31:0] rd_data = (adr_i == LVD_ADDR_CTRL) ? rd_ctrl :
                          (adr_i == LVD_ADDR_IRQF) ? rd_irqf :
                          (adr_i == LVD_ADDR_MASK) ? rd_mask :
                          (adr_i == LVD_ADDR_STAT) ? rd_stat : 32'h0000_0000;
    logic [31:0] dat_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= bus_req;
            dat_reg <= bus_req ? rd_data : dat_reg;
        end
    end
    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

    // ==========================================================
    // checks
    a_mask_after_reset: assert property (@(posedge clk_i) $fell(rst_i) |-> detector_irq_mask)
        else $error("mask not set after reset");
    a_cross_flags_req: assert property (@(posedge clk_i) disable iff (rst_i)
        request_pulse |=> low_voltage_irq_o && detector_irq_request_flag)
        else $error("crossing did not raise request");
    a_stop_below_req: assert property (@(posedge clk_i) disable iff (rst_i)
        (stop_below && irq_mode) |=> detector_irq_request_flag)
        else $error("stop below threshold gave no request");
    a_off_no_level: assert property (@(posedge clk_i) disable iff (rst_i)
        !detector_on_reg |=> !level_below_flag_reg)
        else $error("level flag set while off");
    a_level_tracks: assert property (@(posedge clk_i) disable iff (rst_i)
        detector_on_reg && $stable(detector_on_reg) |=> level_below_flag_reg == $past(sensed_below))
        else $error("level flag wrong");
    a_reset_mode_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (detector_on_reg && reset_or_irq_select_reg && sensed_below) |=> internal_reset_o)
        else $error("internal reset missing");
    a_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        low_voltage_irq_o |=> !low_voltage_irq_o)
        else $error("request longer than one cycle");
    a_irq_no_reset: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_mode |=> !internal_reset_o)
        else $error("reset produced in interrupt mode");
    a_req_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_irqf && !dat_i[LVD_BIT_REQ] && !request_pulse) |=> !detector_irq_request_flag)
        else $error("request flag not cleared");
    c_falling: cover property (@(posedge clk_i) disable iff (rst_i) crossing && sensed_below);
    c_rising: cover property (@(posedge clk_i) disable iff (rst_i) crossing && !sensed_below);
    c_stop_below: cover property (@(posedge clk_i) disable iff (rst_i) stop_below);
    c_irq_out: cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
endmodule : lvd_ctrl

// File: testbench/lvd_comparator.sv
// partner: analog comparator pair feeding the detector
`timescale 1ns/1ps
module lvd_comparator (
    input wire logic clk_i,
    input wire logic supply_low_i,
    input wire logic ext_low_i,
    output logic supply_below_o,
    output logic external_below_o
);
    initial begin
        supply_below_o = 1'b0;
        external_below_o = 1'b0;
    end
    // outputs move on the falling edge: an analog level has no relation to the sampling edge
    always @(negedge clk_i) begin
        supply_below_o <= supply_low_i;
        external_below_o <= ext_low_i;
    end
endmodule : lvd_comparator

// File: testbench/tb.sv
// testbench: wishbone driver, read monitor and detector scenarios
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t mismatch", $time); end end
module tb;
    import lvd_pkg::*;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    localparam logic [31:0] NONE = 32'h0000_0000;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [3:0] adr_i = 4'h0;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] rng = 32'h0000_23AD;
    logic [31:0] r;
    logic [31:0] dat_o;
    logic ack_o, low_voltage_irq_o, internal_reset_o, irq_o, sup_b, ext_b;
    logic sup_t = 1'b0;
    logic ext_t = 1'b0;
    int errors = 0;
    int checks = 0;
    int pulses = 0;
    logic [63:0] exp_q[$];
    initial forever #20 clk_i = ~clk_i;
    lvd_comparator cmp_u (.clk_i(clk_i), .supply_low_i(sup_t), .ext_low_i(ext_t),
        .supply_below_o(sup_b), .external_below_o(ext_b));
    lvd_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .supply_below_i(sup_b), .external_below_i(ext_b), .low_voltage_irq_o(low_voltage_irq_o),
        .internal_reset_o(internal_reset_o), .irq_o(irq_o));
    // ==========
    // helpers
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs
    task test_done();
        if (errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask : idle
    // one classic cycle; the read note is {expected, mask}, writes carry a zero mask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
        int n;
        exp_q.push_back({d & m, m});
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'h1;
        dat_i <= w ? d : xs();
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) begin
            errors++;
            $display("[ERR] %0t bus timeout", $time);
            test_done();
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    // ==========
    // monitor
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && exp_q.size() > 0) begin
            `CHK(dat_o & exp_q[0][31:0], exp_q[0][63:32])
            void'(exp_q.pop_front());
        end
        if (low_voltage_irq_o === 1'b1) pulses++;
    end
    // ==========
    // scenarios
    initial begin
        idle(10);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(0, LVD_ADDR_MASK, 32'h0000_0001, ALL);
        wb(0, LVD_ADDR_CTRL, 32'h0000_0000, ALL);
        wb(0, LVD_ADDR_IRQF, 32'h0000_0000, ALL);
        wb(1, 4'h6, xs(), NONE);
        wb(0, 4'h6, 32'h0000_0000, ALL);
        `CHK(irq_o, 1'b0)
        wb(1, LVD_ADDR_MASK, 32'h0000_0001, NONE);
        wb(1, LVD_ADDR_CTRL, 32'h0000_0000, NONE);
        wb(1, LVD_ADDR_CTRL, 32'h0000_0080, NONE);
        idle(LVD_STAB_CYCLES);
        wb(0, LVD_ADDR_CTRL, 32'h0000_0080, ALL);
        sup_t <= 1'b1;
        idle(8);
        `CHK(pulses, 1)
        wb(1, LVD_ADDR_CTRL, 32'h0000_0080, NONE);
        wb(0, LVD_ADDR_CTRL, 32'h0000_0081, ALL);
        wb(0, LVD_ADDR_IRQF, 32'h0000_0001, ALL);
        `CHK(irq_o, 1'b0)
        wb(1, LVD_ADDR_IRQF, 32'h0000_0000, NONE);
        wb(1, LVD_ADDR_MASK, 32'h0000_0000, NONE);
        `CHK(irq_o, 1'b0)
        sup_t <= 1'b0;
        idle(8);
        `CHK(pulses, 2)
        `CHK(irq_o, 1'b1)
        wb(0, LVD_ADDR_CTRL, 32'h0000_0080, ALL);
        wb(1, LVD_ADDR_IRQF, 32'h0000_0000, NONE);
        `CHK(irq_o, 1'b0)
        wb(1, LVD_ADDR_CTRL, 32'h0000_0084, NONE);
        repeat (20) begin
            r = xs();
            sup_t <= r[0];
            @(posedge clk_i);
        end
        sup_t <= 1'b0;
        idle(8);
        `CHK(pulses, 2)
        ext_t <= 1'b1;
        idle(8);
        `CHK(pulses, 3)
        `CHK(irq_o, 1'b1)
        wb(1, LVD_ADDR_IRQF, 32'h0000_0000, NONE);
        wb(1, LVD_ADDR_CTRL, 32'h0000_0000, NONE);
        idle(4);
        `CHK(pulses, 4)
        wb(0, LVD_ADDR_IRQF, 32'h0000_0001, ALL);
        wb(0, LVD_ADDR_CTRL, 32'h0000_0000, ALL);
        wb(1, LVD_ADDR_MASK, 32'h0000_0001, NONE);
        wb(1, LVD_ADDR_CTRL, 32'h0000_0086, NONE);
        idle(8);
        `CHK(internal_reset_o, 1'b1)
        `CHK(pulses, 4)
        ext_t <= 1'b0;
        idle(8);
        `CHK(internal_reset_o, 1'b0)
        wb(0, LVD_ADDR_STAT, 32'h0000_0003, ALL);
        wb(1, LVD_ADDR_STAT, 32'h0000_0003, NONE);
        wb(0, LVD_ADDR_STAT, 32'h0000_0000, ALL);
        wb(1, LVD_ADDR_MASK, 32'h0000_0000, NONE);
        `CHK(irq_o, 1'b1)
        rst_i <= 1'b1;
        idle(2);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(0, LVD_ADDR_MASK, 32'h0000_0001, ALL);
        test_done();
    end
endmodule : tb
